/* core/coil_cmd_pkg.sv */
// Constants and carrier types for the coil teach and jog command interpreter
package coil_cmd_pkg;
  // Frame characters
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam int FRAME_LEN = 17;
  // Address field
  localparam logic [7:0] ADDR_BROADCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'h10;
  // Function and coil addresses
  localparam logic [7:0] FUNC_COIL_WRITE = 8'h05;
  localparam logic [15:0] COIL_INCH_SELECT = 16'h0411;
  localparam logic [15:0] COIL_TEACH_MODE = 16'h0414;
  localparam logic [15:0] COIL_CAPTURE = 16'h0415;
  localparam logic [15:0] COIL_JOG_POS = 16'h0416;
  localparam logic [15:0] COIL_JOG_NEG = 16'h0417;
  localparam logic [15:0] DATA_ON = 16'hff00;
  localparam logic [15:0] DATA_OFF = 16'h0000;
  // Alarm raised by a held capture before homing
  localparam logic [7:0] ALARM_CAPTURE_NO_HOME = 8'h93;
  // Hold time of the capture command
  localparam int CLK_HZ = 10_000_000;
  localparam int CAPTURE_HOLD_MS = 20;
  localparam int CAPTURE_HOLD_CYC = CLK_HZ / 1000 * CAPTURE_HOLD_MS;
  // Slot field widths
  localparam int POS_W = 32;
  localparam int SLOT_W = 6;
  // One position slot
  typedef struct packed {
    logic [POS_W-1:0] position;
    logic [15:0] positioning_band;
    logic [15:0] slot_speed;
    logic [15:0] slot_acceleration;
    logic [7:0] slot_control_flag;
    logic [4:0] empty_mask; // Band, speed, accel, flag, position empty
  } slot_t;
  // Default parameters used for empty fields
  typedef struct packed {
    logic [15:0] positioning_band;
    logic [15:0] slot_speed;
    logic [15:0] slot_acceleration;
    logic [7:0] slot_control_flag;
  } slot_defaults_t;
  // Motion request to the profile generator
  typedef struct packed {
    logic jog_run;
    logic inch_start;
    logic stop;
  } motion_req_t;
  // Hex character to nibble
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    if (c >= 8'h41 && c <= 8'h46)
    begin
      return 4'(c - 8'h37);
    end
    return c[3:0];
  endfunction : hex_val
  // Hex character check
  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction : is_hex
endpackage : coil_cmd_pkg

/* core/slot_mem.sv */
// Position slot memory with registered read data
`timescale 1ns/1ps
module slot_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic core_clk, // System clock
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] addr, // Slot index
  input wire coil_cmd_pkg::slot_t wdata, // Write data
  output coil_cmd_pkg::slot_t rdata // Registered read data
);
  import coil_cmd_pkg::*;
  slot_t mem [DEPTH]; // Slot store, contents undefined until written
  // Registered read returns the old data on a write
  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : slot_mem

/* core/coil_cmd_core.sv */
// Coil write interpreter for position capture and jog commands
// Rules of the coil command protocol
// R01: Capture only while teaching mode selected
// R02: Capture stores position into selected slot
// R03: Empty slot fields take default values
// R04: Master holds capture on for 20 ms
// R05: Held capture without homing raises alarm 093
// R06: Address is axis plus one, 00 broadcasts
// R07: Function code 05 single coil write
// R08: Coil 0415 capture, 0416 positive jog
// R09: Data FF00 means on, 0000 off
// R10: Colon, fields, LRC, CRLF, 17 characters
// R11: Successful write echoes the query; a broadcast write gets no echo
// R12: Jog on moves away from home
// R13: Off or negative jog stops positive jog
// R14: Inching starts only on off-to-on edge
// R15: Master writes off after jog finishes
// R16: Coil 0411 on selects inching
// R17: Coil 0414 on selects teaching mode
// R18: LRC is negated byte sum; mismatches dropped
`timescale 1ns/1ps
module coil_cmd_core #(
  parameter int SLOTS = 64, // Number of position slots
  parameter int HOLD_CYC = coil_cmd_pkg::CAPTURE_HOLD_CYC // Capture hold
) (
  input wire logic core_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic [3:0] axis_number, // Axis number of this node
  input wire logic rx_valid, // Received character strobe
  input wire logic [7:0] rx_char, // Received character
  input wire logic tx_ready, // Transmitter takes a character
  input wire logic [5:0] slot_select, // Position number selection
  input wire logic [31:0] present_position, // Actuator position
  input wire logic home_done, // Homing completed
  input wire logic motion_busy, // Actuator moving
  input wire coil_cmd_pkg::slot_defaults_t slot_defaults, // Defaults
  output logic tx_valid, // Echo character valid
  output logic [7:0] tx_char, // Echo character
  output coil_cmd_pkg::motion_req_t motion_req, // Motion request
  output logic teach_mode_select, // Teaching mode active
  output logic inch_select, // Inching selected
  output logic alarm_valid, // Alarm present
  output logic [7:0] alarm_code, // Alarm code
  output logic capture_done // Capture written pulse
);
  import coil_cmd_pkg::*;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b00, // Waiting for colon
    ST_RECV = 2'b01, // Collecting characters
    ST_ECHO = 2'b10, // Sending reply
    ST_CAPT = 2'b11 // Never entered; the slot merge runs in the capture block
  } state_t;

  state_t state_reg;
  logic [7:0] frame_reg [FRAME_LEN]; // Stored query for echo
  logic [4:0] idx_reg; // Character index
  logic capture_on_reg; // Capture coil level
  logic jog_pos_reg; // Positive jog coil level
  logic [$clog2(HOLD_CYC+1)-1:0] hold_reg; // Capture hold counter
  slot_t rd_slot; // Slot read back
  logic slot_we_reg; // Slot write strobe
  slot_t slot_wdata_reg; // Slot write data

  // Field decode from the stored frame
  wire [7:0] f_addr = {hex_val(frame_reg[1]), hex_val(frame_reg[2])};
  wire [7:0] f_func = {hex_val(frame_reg[3]), hex_val(frame_reg[4])};
  wire [15:0] f_coil = {hex_val(frame_reg[5]), hex_val(frame_reg[6]),
    hex_val(frame_reg[7]), hex_val(frame_reg[8])};
  wire [15:0] f_data = {hex_val(frame_reg[9]), hex_val(frame_reg[10]),
    hex_val(frame_reg[11]), hex_val(frame_reg[12])};
  wire [7:0] f_lrc = {hex_val(frame_reg[13]), hex_val(frame_reg[14])};
  wire [7:0] byte_sum = f_addr + f_func + f_coil[15:8] + f_coil[7:0]
    + f_data[15:8] + f_data[7:0];
  wire lrc_ok = (8'(~byte_sum + 8'h01) == f_lrc); // R18
  wire [7:0] my_addr = {4'h0, axis_number} + 8'h01;
  wire addr_hit = (f_addr == my_addr) || (f_addr == ADDR_BROADCAST); // R06
  wire data_ok = (f_data == DATA_ON) || (f_data == DATA_OFF); // R09
  wire func_ok = (f_func == FUNC_COIL_WRITE); // R07
  wire last_char = rx_valid && (state_reg == ST_RECV)
    && (idx_reg == 5'(FRAME_LEN - 1));
  wire trailer_ok = (frame_reg[15] == CH_CR) && (rx_char == CH_LF); // R10
  wire frame_good = last_char && trailer_ok && lrc_ok && addr_hit
    && func_ok && data_ok;
  wire is_on = (f_data == DATA_ON);
  wire do_capture = frame_good && (f_coil == COIL_CAPTURE) && is_on
    && teach_mode_select; // R01
  wire jog_write = frame_good && (f_coil == COIL_JOG_POS);
  wire neg_jog_on = frame_good && (f_coil == COIL_JOG_NEG) && is_on;

  // Receive, decode and echo sequencer
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= ST_HUNT;
      idx_reg <= 5'h00;
      tx_valid <= 1'b0;
      tx_char <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        ST_HUNT:
        begin
          if (rx_valid && rx_char == CH_COLON) // R10
          begin
            idx_reg <= 5'h01;
            state_reg <= ST_RECV;
          end
        end
        ST_RECV:
        begin
          // A stray colon restarts the frame
          if (rx_valid && rx_char == CH_COLON)
          begin
            idx_reg <= 5'h01;
          end
          // Address through check characters must all be hex digits
          else if (rx_valid && idx_reg < 5'd15 && !is_hex(rx_char))
          begin
            state_reg <= ST_HUNT;
          end
          else if (last_char)
          begin
            // Broadcasts are obeyed but never answered
            if (frame_good && f_addr != ADDR_BROADCAST) // R11
            begin
              idx_reg <= 5'h00;
              state_reg <= ST_ECHO;
            end
            else
            begin
              state_reg <= ST_HUNT;
            end
          end
          else if (rx_valid)
          begin
            idx_reg <= idx_reg + 5'h01;
          end
        end
        ST_ECHO:
        begin
          // Echo the stored query one character per accept
          if (!tx_valid || tx_ready)
          begin
            if (idx_reg == 5'(FRAME_LEN))
            begin
              tx_valid <= 1'b0;
              state_reg <= ST_HUNT;
            end
            else
            begin
              tx_valid <= 1'b1;
              tx_char <= frame_reg[idx_reg];
              idx_reg <= idx_reg + 5'h01;
            end
          end
        end
        default:
        begin
          state_reg <= ST_HUNT;
        end
      endcase
    end
  end

  // Character store; LF lands as well so the echo is exact
  always_ff @(posedge core_clk)
  begin
    if (rx_valid && rx_char == CH_COLON)
    begin
      frame_reg[0] <= CH_COLON;
    end
    else if (rx_valid && state_reg == ST_RECV)
    begin
      frame_reg[idx_reg] <= rx_char;
    end
  end

  // Mode coils and command levels
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      teach_mode_select <= 1'b0;
      inch_select <= 1'b0;
      capture_on_reg <= 1'b0;
      jog_pos_reg <= 1'b0;
      motion_req <= '0;
    end
    else
    begin
      motion_req <= '0;
      if (frame_good && f_coil == COIL_TEACH_MODE)
      begin
        teach_mode_select <= is_on; // R17
      end
      if (frame_good && f_coil == COIL_INCH_SELECT)
      begin
        inch_select <= is_on; // R16
      end
      if (frame_good && f_coil == COIL_CAPTURE)
      begin
        capture_on_reg <= is_on; // R08
      end
      if (jog_write)
      begin
        jog_pos_reg <= is_on; // R08
        if (!inch_select && is_on)
        begin
          motion_req.jog_run <= 1'b1; // R12
        end
        else if (inch_select && is_on && !jog_pos_reg)
        begin
          motion_req.inch_start <= 1'b1; // R14
        end
        else if (!is_on && motion_busy && !inch_select)
        begin
          motion_req.stop <= 1'b1; // R13
        end
      end
      if (neg_jog_on && jog_pos_reg && motion_busy && !inch_select)
      begin
        motion_req.stop <= 1'b1; // R13
      end
    end
  end

  // Held capture without homing raises the alarm
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      hold_reg <= '0;
      alarm_valid <= 1'b0;
      alarm_code <= 8'h00;
    end
    else if (!capture_on_reg || home_done)
    begin
      hold_reg <= '0;
    end
    else if (hold_reg == ($bits(hold_reg))'(HOLD_CYC - 1))
    begin
      alarm_valid <= 1'b1; // R05
      alarm_code <= ALARM_CAPTURE_NO_HOME; // R05
    end
    else
    begin
      hold_reg <= hold_reg + 1'b1;
    end
  end

  // Capture: read slot, then merge position and defaults
  logic cap_pend_reg; // Read issued, merge once the wait count reaches zero
  logic [1:0] cap_wait_reg; // Read latency
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cap_pend_reg <= 1'b0;
      cap_wait_reg <= 2'h0;
      slot_we_reg <= 1'b0;
      slot_wdata_reg <= '0;
      capture_done <= 1'b0;
    end
    else
    begin
      slot_we_reg <= 1'b0;
      capture_done <= 1'b0;
      if (do_capture)
      begin
        cap_pend_reg <= 1'b1;
        cap_wait_reg <= 2'h2;
      end
      else if (cap_pend_reg && cap_wait_reg != 2'h0)
      begin
        cap_wait_reg <= cap_wait_reg - 2'h1;
      end
      else if (cap_pend_reg)
      begin
        cap_pend_reg <= 1'b0;
        slot_we_reg <= 1'b1;
        capture_done <= 1'b1;
        slot_wdata_reg.position <= present_position; // R02
        slot_wdata_reg.positioning_band <= rd_slot.empty_mask[4] ?
          slot_defaults.positioning_band : rd_slot.positioning_band; // R03
        slot_wdata_reg.slot_speed <= rd_slot.empty_mask[3] ?
          slot_defaults.slot_speed : rd_slot.slot_speed; // R03
        slot_wdata_reg.slot_acceleration <= rd_slot.empty_mask[2] ?
          slot_defaults.slot_acceleration : rd_slot.slot_acceleration; // R03
        slot_wdata_reg.slot_control_flag <= rd_slot.empty_mask[1] ?
          slot_defaults.slot_control_flag : rd_slot.slot_control_flag; // R03
        slot_wdata_reg.empty_mask <= 5'h00;
      end
    end
  end

  // Slot store; empty flags of an unwritten slot are not modelled
  slot_mem #(.DEPTH(SLOTS), .AW(SLOT_W)) u_slot_mem (
    .core_clk(core_clk),
    .we(slot_we_reg),
    .addr(slot_select),
    .wdata(slot_wdata_reg),
    .rdata(rd_slot)
  );
endmodule : coil_cmd_core

/* bench/coil_cmd_chk.sv */
// Port-level checks on the coil command interpreter
`timescale 1ns/1ps
module coil_cmd_chk (
  input wire logic core_clk, // Clock
  input wire logic reset, // Reset
  input wire logic home_done, // Homed
  input wire logic motion_busy, // Moving
  input wire logic tx_ready, // Sink ready
  input wire logic tx_valid, // Echo valid
  input wire logic [7:0] tx_char, // Echo char
  input wire coil_cmd_pkg::motion_req_t motion_req, // Motion pulses
  input wire logic teach_mode_select, // Teach level
  input wire logic inch_select, // Inch level
  input wire logic alarm_valid, // Alarm
  input wire logic [7:0] alarm_code, // Alarm code
  input wire logic capture_done // Capture pulse
);
  import coil_cmd_pkg::*;
  logic [4:0] n_reg; // Echo char position
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Position in the echo, so header and trailer can be pinned
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      n_reg <= 5'h00;
    else if (tx_valid && tx_ready)
      n_reg <= (n_reg == 5'h10) ? 5'h00 : n_reg + 5'h01;
  end
  property p_alarm_code;
    alarm_valid |-> alarm_code == ALARM_CAPTURE_NO_HOME;
  endproperty
  a_alarm_code: assert property (p_alarm_code) else $error("bad code");
  property p_alarm_hold;
    alarm_valid |=> alarm_valid;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm lost");
  property p_alarm_home;
    $rose(alarm_valid) |-> !$past(home_done);
  endproperty
  a_alarm_home: assert property (p_alarm_home) else $error("homed");
  property p_cap_teach;
    capture_done |-> teach_mode_select;
  endproperty
  a_cap_teach: assert property (p_cap_teach) else $error("no teach");
  property p_jog_mode;
    motion_req.jog_run |-> !inch_select;
  endproperty
  a_jog_mode: assert property (p_jog_mode) else $error("jog in inch");
  property p_inch_mode;
    motion_req.inch_start |-> inch_select ##1 !motion_req.inch_start;
  endproperty
  a_inch_mode: assert property (p_inch_mode) else $error("inch bad");
  property p_stop_busy;
    motion_req.stop |-> $past(motion_busy);
  endproperty
  a_stop_busy: assert property (p_stop_busy) else $error("idle stop");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_char);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("echo moved");
  property p_echo_head;
    tx_valid && n_reg == 5'h00 |-> tx_char == CH_COLON;
  endproperty
  a_echo_head: assert property (p_echo_head) else $error("no colon");
  property p_echo_end;
    tx_valid && tx_ready && n_reg == 5'h10 |-> tx_char == CH_LF ##1 !tx_valid;
  endproperty
  a_echo_end: assert property (p_echo_end) else $error("bad end");
  c_capture: cover property (capture_done);
  c_inch: cover property (motion_req.inch_start);
  c_alarm: cover property ($rose(alarm_valid));
endmodule : coil_cmd_chk
bind coil_cmd_core coil_cmd_chk u_chk (.core_clk(core_clk), .reset(reset),
  .home_done(home_done), .motion_busy(motion_busy), .tx_ready(tx_ready),
  .tx_valid(tx_valid), .tx_char(tx_char), .motion_req(motion_req),
  .teach_mode_select(teach_mode_select), .inch_select(inch_select),
  .alarm_valid(alarm_valid), .alarm_code(alarm_code),
  .capture_done(capture_done));

/* bench/modbus_master_model.sv */
// Host model that sends coil write queries and takes the echo
`timescale 1ns/1ps
module modbus_master_model (
  input wire logic core_clk, // Clock
  input wire logic slow, // Stall the echo sink
  input wire logic tx_valid, // Echo valid
  input wire logic [7:0] tx_char, // Echo char
  output logic rx_valid, // Char strobe
  output logic [7:0] rx_char, // Char line
  output logic tx_ready // Sink ready
);
  import coil_cmd_pkg::*;
  logic [7:0] sent [$]; // Chars of this query
  logic [7:0] got [$]; // Echo chars taken
  logic [1:0] k = 2'h0; // Stall phase
  initial
  begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  // Slow sink takes one char in four
  always @(negedge core_clk)
  begin
    k <= k + 2'h1;
    tx_ready <= !slow || k == 2'h0;
  end
  // Echo char taken where ready is seen
  always @(posedge core_clk)
    if (tx_valid === 1'b1 && tx_ready)
      got.push_back(tx_char);
  function automatic logic [7:0] asc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction : asc
  // Line shows the inverse between strobes, never a stale char
  task automatic put(input logic [7:0] c);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_char = c;
    sent.push_back(c);
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_char = ~c;
  endtask : put
  // High nibble first
  task automatic hx(input logic [7:0] b);
    put(asc(b[7:4]));
    put(asc(b[3:0]));
  endtask : hx
  // Whole query; lx spoils the check on purpose
  task automatic send(input logic [7:0] a, f, input logic [15:0] c, d,
                      input logic [7:0] lx);
    logic [7:0] b [6];
    logic [7:0] s;
    b = '{a, f, c[15:8], c[7:0], d[15:8], d[7:0]};
    s = 8'h00;
    foreach (b[i]) s += b[i];
    put(CH_COLON);
    foreach (b[i]) hx(b[i]);
    hx((8'h00 - s) ^ lx);
    put(CH_CR);
    put(CH_LF);
  endtask : send
endmodule : modbus_master_model

/* bench/test_coil_teach_and_jog_commands.sv */
// Self-checking bench for the coil command interpreter
`timescale 1ns/1ps
module test_coil_teach_and_jog_commands;
  import coil_cmd_pkg::*;
  logic core_clk = 1'b0; // Clock
  logic reset = 1'b1; // Reset
  logic [3:0] axis_number = 4'h0; // Node axis
  logic [5:0] slot_select = 6'h00; // Slot index
  logic [31:0] present_position = 32'h0; // Position
  logic home_done = 1'b1; // Homed
  logic motion_busy = 1'b0; // Moving
  logic slow = 1'b0; // Echo sink stalls
  slot_defaults_t slot_defaults = '0; // Defaults
  logic rx_valid, tx_ready, tx_valid, capture_done; // Handshakes
  logic [7:0] rx_char, tx_char, alarm_code, an; // Chars, node address
  logic teach_mode_select, inch_select, alarm_valid; // Levels
  motion_req_t motion_req; // Motion pulses
  int n_mismatch = 0, comparisons = 0;
  int n_jog = 0, n_inch = 0, n_stop = 0, n_cap = 0; // Seen pulses
  int m_jog = 0, m_inch = 0, m_stop = 0, m_cap = 0; // Model pulses
  int m_teach = 0, m_inchsel = 0, m_jp = 0, m_alarm = 0; // Model levels
  logic [31:0] seed = 32'h0000d23b; // Xorshift state
  always #50 core_clk = ~core_clk;
  coil_cmd_core #(.SLOTS(64), .HOLD_CYC(20)) dut (.core_clk(core_clk),
    .reset(reset), .axis_number(axis_number), .rx_valid(rx_valid),
    .rx_char(rx_char), .tx_ready(tx_ready), .slot_select(slot_select),
    .present_position(present_position), .home_done(home_done),
    .motion_busy(motion_busy), .slot_defaults(slot_defaults),
    .tx_valid(tx_valid), .tx_char(tx_char), .motion_req(motion_req),
    .teach_mode_select(teach_mode_select), .inch_select(inch_select),
    .alarm_valid(alarm_valid), .alarm_code(alarm_code),
    .capture_done(capture_done));
  modbus_master_model m (.core_clk(core_clk), .slow(slow),
    .tx_valid(tx_valid), .tx_char(tx_char), .rx_valid(rx_valid),
    .rx_char(rx_char), .tx_ready(tx_ready));
  // Pulse tallies
  always @(posedge core_clk)
  begin
    if (motion_req.jog_run === 1'b1) n_jog++;
    if (motion_req.inch_start === 1'b1) n_inch++;
    if (motion_req.stop === 1'b1) n_stop++;
    if (capture_done === 1'b1) n_cap++;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask : check
  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // One query, then echo and model compared
  task automatic frame(input logic [7:0] a, f, input logic [15:0] c, d,
                       input logic [7:0] lx);
    int ok, on, i;
    slot_select = 6'(rnd());
    present_position = rnd();
    slot_defaults = 56'({rnd(), rnd()});
    m.sent.delete();
    m.got.delete();
    m.send(a, f, c, d, lx);
    on = (d == DATA_ON);
    ok = (a == an || a == 8'h00) && f == 8'h05 && lx == 8'h00
         && (on || d == DATA_OFF);
    for (i = 0; i < 150 && m.got.size() < 17; i++)
      @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    if (ok && a != 8'h00)
      foreach (m.sent[j]) check(m.got[j], m.sent[j]);
    check(m.got.size(), (ok && a != 8'h00) ? 17 : 0);
    if (ok)
      case (c)
        COIL_TEACH_MODE: m_teach = on;
        COIL_INCH_SELECT: m_inchsel = on;
        COIL_CAPTURE: m_cap += on && m_teach;
        COIL_JOG_POS:
        begin
          if (on && m_inchsel && !m_jp) m_inch++;
          if (on && !m_inchsel) m_jog++;
          if (!on && !m_inchsel && motion_busy) m_stop++;
          m_jp = on;
        end
        COIL_JOG_NEG: m_stop += on && m_jp && motion_busy && !m_inchsel;
        default: ;
      endcase
    check(teach_mode_select, m_teach);
    check(inch_select, m_inchsel);
    check(n_cap, m_cap);
    check(n_jog, m_jog);
    check(n_inch, m_inch);
    check(n_stop, m_stop);
    check(alarm_valid, m_alarm);
  endtask : frame
  // Main sequence
  initial
  begin
    axis_number = 4'(rnd());
    an = 8'(axis_number) + 8'h01;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    frame(an, 8'h05, COIL_CAPTURE, DATA_ON, 8'h00);
    frame(an, 8'h05, COIL_CAPTURE, DATA_OFF, 8'h00);
    frame(an, 8'h05, COIL_TEACH_MODE, DATA_ON, 8'h00);
    slow = 1'b1;
    frame(an, 8'h05, COIL_CAPTURE, DATA_ON, 8'h00);
    repeat (30) @(negedge core_clk);
    frame(an, 8'h05, COIL_CAPTURE, DATA_OFF, 8'h00);
    // Refused queries must leave teaching mode on; the broadcast that follows turns it off
    frame(an, 8'h05, COIL_TEACH_MODE, DATA_OFF, 8'h5a);
    frame(an + 8'h01, 8'h05, COIL_TEACH_MODE, DATA_OFF, 8'h00);
    frame(an, 8'h06, COIL_TEACH_MODE, DATA_OFF, 8'h00);
    frame(an, 8'h05, COIL_TEACH_MODE, 16'h1234, 8'h00);
    frame(8'h00, 8'h05, COIL_TEACH_MODE, DATA_OFF, 8'h00);
    frame(an, 8'h05, COIL_INCH_SELECT, DATA_OFF, 8'h00);
    frame(an, 8'h05, COIL_JOG_POS, DATA_ON, 8'h00);
    motion_busy = 1'b1;
    frame(an, 8'h05, COIL_JOG_POS, DATA_OFF, 8'h00);
    frame(an, 8'h05, COIL_JOG_POS, DATA_ON, 8'h00);
    frame(an, 8'h05, COIL_JOG_NEG, DATA_ON, 8'h00);
    frame(an, 8'h05, COIL_JOG_NEG, DATA_OFF, 8'h00);
    motion_busy = 1'b0;
    frame(an, 8'h05, COIL_JOG_POS, DATA_OFF, 8'h00);
    frame(an, 8'h05, COIL_INCH_SELECT, DATA_ON, 8'h00);
    frame(an, 8'h05, COIL_JOG_POS, DATA_ON, 8'h00);
    frame(an, 8'h05, COIL_JOG_POS, DATA_ON, 8'h00);
    frame(an, 8'h05, COIL_JOG_POS, DATA_OFF, 8'h00);
    // Held capture before homing; slow echo outlasts the hold
    home_done = 1'b0;
    m_alarm = 1;
    frame(an, 8'h05, COIL_CAPTURE, DATA_ON, 8'h00);
    check(alarm_code, ALARM_CAPTURE_NO_HOME);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    check(alarm_valid, 1'b0);
    check(inch_select, 1'b0);
    reset = 1'b0;
    conclude();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    conclude();
  end
endmodule : test_coil_teach_and_jog_commands
